//--- verilog/cfa_defines.svh
// register offsets, field positions and reset values of the camera fault-fix block
`ifndef CFA_DEFINES_SVH
`define CFA_DEFINES_SVH

// ****************************************
// register offsets
// ****************************************
`define CFA_OFS_FIX_CTRL    8'h00
`define CFA_OFS_FIX_BASE    8'h04
`define CFA_OFS_IRQ_TIMING  8'h08
`define CFA_OFS_COMPANDING  8'h0C
`define CFA_OFS_SYNC_POL    8'h10

// ****************************************
// field positions
// ****************************************
`define CFA_FIX_ERR_BIT     16
`define CFA_FIX_EN_BIT      15
`define CFA_FIX_CNT_MSB     14
`define CFA_BASE_LSB        6
`define CFA_IRQ0_MSB        30
`define CFA_IRQ0_LSB        16
`define CFA_IRQ1_MSB        14
`define CFA_IRQ1_LSB        0
`define CFA_CMP_EN_BIT      3
`define CFA_CMP_WIN_MSB     2
`define CFA_POL_FRAME_BIT   0
`define CFA_POL_LINE_BIT    1

// ****************************************
// reset values and fixed counts
// ****************************************
`define CFA_RST_IRQ_TIMING  32'h0000_0000
`define CFA_RST_CMP_WIN     3'h4
`define CFA_WIN_RESERVED    3'h7
`define CFA_FIX_REACH       6
`define CFA_OP_LAST         5'h11

`endif

//--- verilog/cfa_pkg.sv
// types shared by the camera fault-fix block
package cfa_pkg;

  // one fault table word: vertical, horizontal, operation
  typedef struct packed {
    logic [12:0] y;
    logic [13:0] x;
    logic [4:0]  op;
  } cfa_entry_t;

  // one pixel of the correction window with its coordinates
  typedef struct packed {
    logic [12:0] y;
    logic [13:0] x;
    logic [15:0] pix;
  } cfa_slot_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] pix;
  } cfa_pix_t;

  typedef enum logic [1:0] {
    FETCH_IDLE,
    FETCH_WAIT,
    FETCH_HOLD
  } cfa_fetch_state_t;

endpackage

//--- verilog/cfa_frame_irq.sv
// line-count interrupts after the frame sync edge
`timescale 1ns/10ps
`include "cfa_defines.svh"
module cfa_frame_irq
  import cfa_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // sync events
  input  wire logic        frameEdge,
  input  wire logic        lineEdge,
  // line counts from software
  input  wire logic [14:0] frameIrq0LineCount,
  input  wire logic [14:0] frameIrq1LineCount,
  // interrupt pulses
  output logic             frameIrq0,
  output logic             frameIrq1
);

  logic [15:0] lineCnt_r;
  logic [15:0] lineCnt_nxt;
  logic        armed_r;

  // a line edge together with the frame edge is not counted
  always_comb begin
    lineCnt_nxt = lineCnt_r;
    if (frameEdge) begin
      lineCnt_nxt = 16'h0000;
    end else if (lineEdge && armed_r && lineCnt_r != 16'hFFFF) begin
      lineCnt_nxt = lineCnt_r + 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lineCnt_r <= 16'h0000;
      armed_r   <= 1'b0;
    end else begin
      lineCnt_r <= lineCnt_nxt;
      if (frameEdge) begin
        armed_r <= 1'b1;
      end
    end
  end

  // pulse once when the count reaches field plus one
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      frameIrq0 <= 1'b0;
      frameIrq1 <= 1'b0;
    end else begin
      frameIrq0 <= !frameEdge && lineEdge && armed_r &&
                   lineCnt_nxt == {1'b0, frameIrq0LineCount} + 16'h0001;
      frameIrq1 <= !frameEdge && lineEdge && armed_r &&
                   lineCnt_nxt == {1'b0, frameIrq1LineCount} + 16'h0001;
    end
  end

endmodule

//--- verilog/cfa_companding_setting_map.sv
// companding of the corrected pixel stream before it goes to memory
`timescale 1ns/10ps
`include "cfa_defines.svh"
module cfa_companding_setting_map
  import cfa_pkg::*;
(
  // clock and reset
  input  wire logic      mclk,
  input  wire logic      nrst,
  // control
  input  wire logic      companding_enable,
  input  wire logic [2:0] companding_input_window,
  // pixel stream
  input  wire cfa_pix_t  pixIn,
  output cfa_pix_t       pixOut
);

  // segment plus five-bit mantissa of a 10-bit value
  function automatic logic [7:0] compress(input logic [9:0] v);
    logic [7:0] r;
    r = {3'h0, v[4:0]};
    for (int p = 5; p <= 9; p++) begin
      if (v[p]) begin
        r = {3'(p - 4), 5'(v >> (p - 5))};
      end
    end
    return r;
  endfunction

  logic [9:0] slice;

  // window 0 takes bits 15-6, each step one bit lower, 6 takes 9-0
  always_comb begin
    slice = 10'h000;
    if (companding_input_window != `CFA_WIN_RESERVED) begin
      slice = 10'(pixIn.pix >> (3'h6 - companding_input_window));
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pixOut <= '0;
    end else begin
      pixOut.valid <= pixIn.valid;
      if (companding_enable) begin
        pixOut.pix <= {8'h00, compress(slice)};
      end else begin
        pixOut.pix <= pixIn.pix;
      end
    end
  end

endmodule

//--- verilog/cfa_fault_fix.sv
// camera input fault pixel correction, frame interrupts and companding
//
// Overview of operation
// - base address keeps bits 31-6 only, so the table is 64-byte aligned.
// - each table word is 13-bit line, 14-bit column, 5-bit operation.
// - operation in bits 4-0 acts on the pixel at the entry's column.
// - codes 0,3,6,9,12,15 average pixels x-k and x+k, k 1 to 6.
// - codes 1,4,7,10,13,16 copy left neighbour x-k, k 1 to 6.
// - codes 2,5,8,11,14,17 copy right neighbour x+k, k 1 to 6.
// - first interrupt fires after first line count field plus one lines.
// - second interrupt fires after second line count field plus one lines.
// - a line edge coinciding with the frame edge is not counted.
// - companding enable maps pixel data to memory as a segment plus five-bit mantissa.
// - input window selects bits 15-6 down to 9-0; value 7 reserved.
// - while enabled, keep fetching entries, wrapping to the start after the last.
// - per-frame fault count is a 15-bit field latched on frame sync.
// - late entry sets sticky error, write 1 clears, no more fixes that frame.
`timescale 1ns/10ps
`include "cfa_defines.svh"
module cfa_fault_fix
  import cfa_pkg::*;
#(
  parameter int SYNC_STAGES = 2
)(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdata,
  // sensor sync pins
  input  wire logic        frame_sync,
  input  wire logic        line_sync,
  // pixel stream from the capture path
  input  wire logic        pixValid,
  input  wire logic [15:0] pixData,
  // fault table fetch
  output logic             memReq,
  output logic [31:0]      memAddr,
  input  wire logic        memAck,
  input  wire logic [31:0] memRdata,
  // pixel stream to memory
  output logic             memPixValid,
  output logic [15:0]      memPix,
  // interrupts
  output logic             frame_irq0,
  output logic             frame_irq1
);

  localparam int WIN = 2 * `CFA_FIX_REACH + 1;

  generate
    if (SYNC_STAGES < 2) begin : g_bad_sync
      $error("SYNC_STAGES must be at least 2");
    end
  endgenerate

  // ****************************************
  // registers
  // ****************************************
  logic        fault_fix_enable_r;
  logic [14:0] fault_fix_count_r;
  logic        fault_fix_late_error_r;
  logic [25:0] fault_table_base_r;
  logic [14:0] frame_irq0_line_count_r;
  logic [14:0] frame_irq1_line_count_r;
  logic        companding_enable_r;
  logic [2:0]  companding_input_window_r;
  logic [1:0]  syncFalling_r;
  logic        lateSet;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fault_fix_enable_r        <= 1'b0;
      fault_fix_count_r         <= 15'h0000;
      fault_table_base_r        <= 26'h000_0000;
      frame_irq0_line_count_r   <= 15'(`CFA_RST_IRQ_TIMING);
      frame_irq1_line_count_r   <= 15'(`CFA_RST_IRQ_TIMING);
      companding_enable_r       <= 1'b0;
      companding_input_window_r <= `CFA_RST_CMP_WIN;
      syncFalling_r             <= 2'h0;
    end else if (regWr) begin
      unique case (regAddr)
        `CFA_OFS_FIX_CTRL: begin
          fault_fix_enable_r <= regWdata[`CFA_FIX_EN_BIT];
          fault_fix_count_r  <= regWdata[`CFA_FIX_CNT_MSB:0];
        end
        `CFA_OFS_FIX_BASE: begin
          fault_table_base_r <= regWdata[31:`CFA_BASE_LSB];
        end
        `CFA_OFS_IRQ_TIMING: begin
          frame_irq0_line_count_r <= regWdata[`CFA_IRQ0_MSB:`CFA_IRQ0_LSB];
          frame_irq1_line_count_r <= regWdata[`CFA_IRQ1_MSB:`CFA_IRQ1_LSB];
        end
        `CFA_OFS_COMPANDING: begin
          companding_enable_r       <= regWdata[`CFA_CMP_EN_BIT];
          companding_input_window_r <= regWdata[`CFA_CMP_WIN_MSB:0];
        end
        `CFA_OFS_SYNC_POL: begin
          syncFalling_r <= regWdata[1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // sticky late error: hardware set wins over the write-one clear
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fault_fix_late_error_r <= 1'b0;
    end else if (lateSet) begin
      fault_fix_late_error_r <= 1'b1;
    end else if (regWr && regAddr == `CFA_OFS_FIX_CTRL && regWdata[`CFA_FIX_ERR_BIT]) begin
      fault_fix_late_error_r <= 1'b0;
    end
  end

  // read data stand in the cycle after the strobe only
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      regRdata <= 32'h0000_0000;
    end else if (regRd) begin
      unique case (regAddr)
        `CFA_OFS_FIX_CTRL:
          regRdata <= {15'h0000, fault_fix_late_error_r, fault_fix_enable_r,
                       fault_fix_count_r};
        `CFA_OFS_FIX_BASE:
          regRdata <= {fault_table_base_r, 6'h00};
        `CFA_OFS_IRQ_TIMING:
          regRdata <= {1'b0, frame_irq0_line_count_r, 1'b0, frame_irq1_line_count_r};
        `CFA_OFS_COMPANDING:
          regRdata <= {28'h000_0000, companding_enable_r, companding_input_window_r};
        `CFA_OFS_SYNC_POL:
          regRdata <= {30'h0000_0000, syncFalling_r};
        default:
          regRdata <= 32'h0000_0000;
      endcase
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

  // ****************************************
  // sync pins and edges
  // ****************************************
  logic [SYNC_STAGES-1:0] frameSyncQ_r;
  logic [SYNC_STAGES-1:0] lineSyncQ_r;
  logic                   frameLast_r;
  logic                   lineLast_r;
  logic                   frameEdge;
  logic                   lineEdge;
  logic                   frameLvl;
  logic                   lineLvl;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      frameSyncQ_r <= '0;
      lineSyncQ_r  <= '0;
      frameLast_r  <= 1'b0;
      lineLast_r   <= 1'b0;
    end else begin
      frameSyncQ_r <= {frameSyncQ_r[SYNC_STAGES-2:0], frame_sync};
      lineSyncQ_r  <= {lineSyncQ_r[SYNC_STAGES-2:0], line_sync};
      frameLast_r  <= frameLvl;
      lineLast_r   <= lineLvl;
    end
  end

  // programmed polarity folds into the level before edge detection
  assign frameLvl  = frameSyncQ_r[SYNC_STAGES-1] ^ syncFalling_r[`CFA_POL_FRAME_BIT];
  assign lineLvl   = lineSyncQ_r[SYNC_STAGES-1] ^ syncFalling_r[`CFA_POL_LINE_BIT];
  assign frameEdge = frameLvl && !frameLast_r;
  assign lineEdge  = lineLvl && !lineLast_r;

  cfa_frame_irq u_irq (
    .mclk               (mclk),
    .nrst               (nrst),
    .frameEdge          (frameEdge),
    .lineEdge           (lineEdge),
    .frameIrq0LineCount (frame_irq0_line_count_r),
    .frameIrq1LineCount (frame_irq1_line_count_r),
    .frameIrq0          (frame_irq0),
    .frameIrq1          (frame_irq1)
  );

  // ****************************************
  // fault table fetch
  // ****************************************
  cfa_fetch_state_t fetchState_r;
  logic [14:0]      fetchIdx_r;
  logic [14:0]      countLat_r;
  cfa_entry_t       entry_r;
  logic             entryUsed;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      countLat_r <= 15'h0000;
    end else if (frameEdge) begin
      countLat_r <= fault_fix_count_r;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fetchState_r <= FETCH_IDLE;
      fetchIdx_r   <= 15'h0000;
      entry_r      <= '0;
      memReq       <= 1'b0;
      memAddr      <= 32'h0000_0000;
    end else begin
      unique case (fetchState_r)
        FETCH_IDLE: begin
          if (fault_fix_enable_r && countLat_r != 15'h0000) begin
            memReq       <= 1'b1;
            memAddr      <= {fault_table_base_r, 6'h00} + {15'h0000, fetchIdx_r, 2'h0};
            fetchState_r <= FETCH_WAIT;
          end else begin
            fetchIdx_r <= 15'h0000;
          end
        end
        FETCH_WAIT: begin
          if (memAck) begin
            memReq       <= 1'b0;
            entry_r      <= cfa_entry_t'(memRdata);
            fetchState_r <= fault_fix_enable_r ? FETCH_HOLD : FETCH_IDLE;
            if (fetchIdx_r + 15'h0001 >= countLat_r) begin
              fetchIdx_r <= 15'h0000;
            end else begin
              fetchIdx_r <= fetchIdx_r + 15'h0001;
            end
          end
        end
        FETCH_HOLD: begin
          if (!fault_fix_enable_r || entryUsed || frameEdge) begin
            fetchState_r <= FETCH_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // correction window
  // ****************************************
  cfa_slot_t   win_r [WIN];
  logic [12:0] yIn_r;
  logic [13:0] xIn_r;
  logic [3:0]  fill_r;
  logic        frameDead_r;
  cfa_pix_t    fixed_r;
  cfa_slot_t   center;
  logic        entryHeld;
  logic        hit;
  logic        passed;
  logic [16:0] fixVal;

  // replacement for one operation code, bit 16 says whether it applies
  function automatic logic [16:0] fixPixel(input logic [4:0] op,
                                           input logic [15:0] left [`CFA_FIX_REACH],
                                           input logic [15:0] right [`CFA_FIX_REACH]);
    logic [16:0] r;
    logic [16:0] sum;
    r = 17'h0_0000;
    for (int k = 0; k < `CFA_FIX_REACH; k++) begin
      sum = {1'b0, left[k]} + {1'b0, right[k]};
      if (op == 5'(3 * k)) begin
        r = {1'b1, sum[16:1]};
      end else if (op == 5'(3 * k + 1)) begin
        r = {1'b1, left[k]};
      end else if (op == 5'(3 * k + 2)) begin
        r = {1'b1, right[k]};
      end
    end
    if (op > `CFA_OP_LAST) begin
      r = 17'h0_0000;
    end
    return r;
  endfunction

  logic [15:0] leftPix  [`CFA_FIX_REACH];
  logic [15:0] rightPix [`CFA_FIX_REACH];

  // slot 0 is the newest pixel, so x+k sits below the center and x-k above
  always_comb begin
    for (int k = 0; k < `CFA_FIX_REACH; k++) begin
      rightPix[k] = win_r[`CFA_FIX_REACH - 1 - k].pix;
      leftPix[k]  = win_r[`CFA_FIX_REACH + 1 + k].pix;
    end
  end

  assign center    = win_r[`CFA_FIX_REACH];
  assign entryHeld = fetchState_r == FETCH_HOLD;
  assign hit       = entryHeld && entry_r.y == center.y && entry_r.x == center.x;
  assign passed    = entryHeld && (entry_r.y < center.y ||
                     (entry_r.y == center.y && entry_r.x < center.x));
  assign fixVal    = fixPixel(entry_r.op, leftPix, rightPix);
  assign entryUsed = pixValid && fill_r == 4'(WIN) && (hit || passed);
  assign lateSet   = pixValid && fill_r == 4'(WIN) && passed && !frameDead_r;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      yIn_r  <= 13'h0000;
      xIn_r  <= 14'h0000;
      fill_r <= 4'h0;
      for (int i = 0; i < WIN; i++) begin
        win_r[i] <= '0;
      end
    end else begin
      if (frameEdge) begin
        yIn_r <= 13'h0000;
        xIn_r <= 14'h0000;
      end else if (lineEdge) begin
        yIn_r <= yIn_r + 13'h0001;
        xIn_r <= 14'h0000;
      end else if (pixValid) begin
        xIn_r <= xIn_r + 14'h0001;
      end
      if (pixValid) begin
        win_r[0] <= '{y: yIn_r, x: xIn_r, pix: pixData};
        for (int i = 1; i < WIN; i++) begin
          win_r[i] <= win_r[i-1];
        end
        if (fill_r != 4'(WIN)) begin
          fill_r <= fill_r + 4'h1;
        end
      end
    end
  end

  // a late entry ends correction until the next frame
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      frameDead_r <= 1'b0;
    end else if (frameEdge) begin
      frameDead_r <= 1'b0;
    end else if (lateSet) begin
      frameDead_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fixed_r <= '0;
    end else begin
      fixed_r.valid <= pixValid && fill_r == 4'(WIN);
      if (hit && !frameDead_r && fixVal[16]) begin
        fixed_r.pix <= fixVal[15:0];
      end else begin
        fixed_r.pix <= center.pix;
      end
    end
  end

  // ****************************************
  // companding to memory
  // ****************************************
  cfa_pix_t memOut;

  cfa_companding_setting_map u_companding_setting (
    .mclk                    (mclk),
    .nrst                    (nrst),
    .companding_enable       (companding_enable_r),
    .companding_input_window (companding_input_window_r),
    .pixIn                   (fixed_r),
    .pixOut                  (memOut)
  );

  assign memPixValid = memOut.valid;
  assign memPix      = memOut.pix;

endmodule

//--- verification/cfa_fault_fix_chk.sv
// assertions on the ports of the camera fault-fix block
`timescale 1ns/10ps
`include "cfa_defines.svh"
module cfa_fault_fix_chk (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  input  wire logic [31:0] regRdata,
  // streams, fetch and interrupts
  input  wire logic        pixValid,
  input  wire logic        memReq,
  input  wire logic [31:0] memAddr,
  input  wire logic        memAck,
  input  wire logic        memPixValid,
  input  wire logic [15:0] memPix,
  input  wire logic        frame_irq0,
  input  wire logic        frame_irq1
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ****
  // shadow copies of the table base, line timing and companding registers
  // ****
  logic [31:0] base_r;
  logic [31:0] timing_r;
  logic [3:0]  cmp_r;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      base_r   <= 32'h0;
      timing_r <= 32'h0;
      cmp_r    <= 4'h4;
    end else if (regWr) begin
      if (regAddr == `CFA_OFS_FIX_BASE) base_r <= regWdata;
      if (regAddr == `CFA_OFS_IRQ_TIMING) timing_r <= regWdata;
      if (regAddr == `CFA_OFS_COMPANDING) cmp_r <= regWdata[3:0];
    end
  end
  // ****
  // properties
  // ****
  AST_REQ_HOLD: assert property (memReq && !memAck |=> memReq && $stable(memAddr))
    else $error("fetch request moved before its answer");
  AST_REQ_DROP: assert property (memReq && memAck |=> !memReq)
    else $error("fetch request still up after its answer");
  AST_ADDR_BASE: assert property (memReq |-> memAddr[1:0] == 2'h0 &&
    memAddr - {base_r[31:6], 6'h00} < 32'h0002_0000)
    else $error("fetch address not on the aligned table base");
  AST_BASE_RD: assert property (regRd && regAddr == `CFA_OFS_FIX_BASE |=>
    regRdata == {base_r[31:6], 6'h00}) else $error("table base read wrong");
  AST_TIMING_RD: assert property (regRd && regAddr == `CFA_OFS_IRQ_TIMING |=>
    regRdata == (timing_r & 32'h7FFF_7FFF)) else $error("line timing read wrong");
  AST_CMP_RD: assert property (regRd && regAddr == `CFA_OFS_COMPANDING |=>
    regRdata == {28'h0, cmp_r}) else $error("companding read wrong");
  AST_IRQ_PULSE: assert property (frame_irq0 || frame_irq1 |=>
    !frame_irq0 && !frame_irq1) else $error("interrupt longer than one cycle");
  AST_PIX_LAT: assert property (memPixValid |-> $past(pixValid, 2))
    else $error("output pixel without input two cycles before");
  AST_CMP_ZERO: assert property (memPixValid && cmp_r[3] && $stable(cmp_r) |->
    memPix[15:8] == 8'h00) else $error("companded pixel has upper byte set");
endmodule

//--- verification/cfa_mem_model.sv
// memory holding the fault table, answering fetches after a set delay
`timescale 1ns/10ps
module cfa_mem_model
  import cfa_pkg::*;
#(
  parameter logic [31:0] BASE = 32'h1000_0000
)(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // fetch port
  input  wire logic        memReq,
  input  wire logic [31:0] memAddr,
  output logic             memAck,
  output logic [31:0]      memRdata,
  // answer delay in cycles
  input  wire logic [7:0]  ackDelay
);
  logic [7:0] wait_r;
  // entries 0 to 19 on line 1, 14 columns apart, operation equal to index
  function automatic cfa_entry_t entryAt(input logic [31:0] a);
    cfa_entry_t  e;
    logic [31:0] i;
    i = (a - BASE) >> 2;
    e.y = (i < 32'h14) ? 13'h0001 : 13'h1F40;
    e.x = 14'(32'hA + 32'hE * i);
    e.op = 5'(i);
    return e;
  endfunction
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      memAck   <= 1'b0;
      memRdata <= 32'h0;
      wait_r   <= 8'h00;
    end else if (!memAck && memReq && wait_r >= ackDelay) begin
      memAck   <= 1'b1;
      memRdata <= entryAt(memAddr);
      wait_r   <= 8'h00;
    end else begin
      // released bus does not keep the last word
      memAck   <= 1'b0;
      memRdata <= ~memRdata;
      wait_r   <= (memReq && !memAck) ? wait_r + 8'h01 : 8'h00;
    end
  end
endmodule

//--- verification/cfa_fault_fix_bench.sv
// self-checking bench of the camera fault-fix block
`timescale 1ns/10ps
`include "cfa_defines.svh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module cfa_fault_fix_bench;
  logic        mclk = 1'b0, nrst = 1'b0, regWr = 1'b0, regRd = 1'b0, rdPrev = 1'b0;
  logic        frame_sync = 1'b0, line_sync = 1'b0, pixValid = 1'b0, cmpEn = 1'b0;
  logic [7:0]  regAddr = 8'h00, memDelay = 8'h01;
  logic [31:0] regWdata = 32'h0, rdExp;
  logic [15:0] pixData = 16'h0000, lfsr = 16'h0013, pixExp;
  logic [2:0]  cmpWin = 3'h4;
  wire  [31:0] regRdata, memAddr, memRdata;
  wire  [15:0] memPix;
  wire         memReq, memAck, memPixValid, frame_irq0, frame_irq1;
  int          errors = 0, n_tests = 0, g = 0, lineStart = 0, lineCnt = 0;
  int          nIrq0 = 0, nIrq1 = 0, opMem[1024];
  bit          fixOn = 1'b0;
  logic [31:0] rdQ[$];
  logic [15:0] pixQ[$], pixMem[1024];

  always #10 mclk = ~mclk;

  cfa_fault_fix cfa_fault_fix_i (.mclk, .nrst, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .frame_sync, .line_sync, .pixValid, .pixData, .memReq, .memAddr,
    .memAck, .memRdata, .memPixValid, .memPix, .frame_irq0, .frame_irq1);
  cfa_mem_model cfa_mem_model_i (.mclk, .nrst, .memReq, .memAddr, .memAck,
    .memRdata, .ackDelay(memDelay));

  // ****
  // stimulus helpers
  // ****
  function automatic logic [15:0] lfsrNext(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] expPix(input int i);
    logic [15:0] v;
    logic [9:0]  s;
    int          k, p;
    v = pixMem[i];
    k = opMem[i] / 3 + 1;
    if (opMem[i] >= 0 && opMem[i] <= 17)
      case (opMem[i] % 3)
        0: v = 16'((17'(pixMem[i-k]) + 17'(pixMem[i+k])) >> 1);
        1: v = pixMem[i-k];
        default: v = pixMem[i+k];
      endcase
    if (cmpEn) begin
      s = (cmpWin == 3'h7) ? 10'h000 : 10'(v >> (6 - cmpWin));
      p = 0;
      for (int b = 0; b < 10; b++) if (s[b]) p = b;
      v = (s < 10'h20) ? {11'h000, s[4:0]} : {8'h00, 3'(p - 4), 5'(s >> (p - 5))};
    end
    return v;
  endfunction
  task wr(input logic [7:0] a, input logic [31:0] d);
    regWr <= 1'b1; regAddr <= a; regWdata <= d;
    @(posedge mclk); regWr <= 1'b0; @(posedge mclk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    regRd <= 1'b1; regAddr <= a; rdQ.push_back(e);
    @(posedge mclk); regRd <= 1'b0; @(posedge mclk);
  endtask
  task sync(input bit f, input bit l);
    if (f) lineCnt = 0;
    else if (l) lineCnt++;
    frame_sync <= f; line_sync <= l; repeat (3) @(posedge mclk);
    frame_sync <= 1'b0; line_sync <= 1'b0; repeat (6) @(posedge mclk);
    if (l) lineStart = g;
  endtask
  task pix(input int n);
    repeat (n) begin
      lfsr = lfsrNext(lfsr);
      pixMem[g] = lfsr;
      opMem[g] = -1;
      if (fixOn && g - lineStart >= 10 && g - lineStart < 290 && (g - lineStart - 10) % 14 == 0)
        opMem[g] = (g - lineStart - 10) / 14;
      pixValid <= 1'b1; pixData <= lfsr;
      if (g >= 13) pixQ.push_back(expPix(g - 7));
      g++; @(posedge mclk);
    end
    pixValid <= 1'b0;
  endtask
  task results;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ****
  // result watcher
  // ****
  always @(posedge mclk) begin
    rdPrev <= regRd;
    if (rdPrev) begin
      rdExp = rdQ.pop_front();
      `CHK("regRdata", rdExp, regRdata)
    end
    if (memPixValid) begin
      pixExp = pixQ.size() > 0 ? pixQ.pop_front() : 16'hXXXX;
      `CHK("memPix", pixExp, memPix)
    end
    if (frame_irq0) begin nIrq0++; `CHK("irq0 lines", 3, lineCnt) end
    if (frame_irq1) begin nIrq1++; `CHK("irq1 lines", 1, lineCnt) end
  end

  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    results();
  end

  // ****
  // main sequence
  // ****
  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1; @(posedge mclk);
    rd(`CFA_OFS_IRQ_TIMING, 32'h0);
    rd(`CFA_OFS_COMPANDING, 32'h4);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0);
    wr(`CFA_OFS_IRQ_TIMING, 32'hFFFF_FFFF);
    rd(`CFA_OFS_IRQ_TIMING, 32'h7FFF_7FFF);
    wr(`CFA_OFS_IRQ_TIMING, 32'h0002_0000);
    wr(`CFA_OFS_FIX_BASE, 32'h1000_0025);
    rd(`CFA_OFS_FIX_BASE, 32'h1000_0000);
    // operation codes 0 to 19 once, reserved 18 and 19 included, entries fetched in turn
    wr(`CFA_OFS_FIX_CTRL, 32'h0000_8015);
    fixOn = 1'b1; sync(1, 0); sync(0, 1); pix(290); sync(0, 1); sync(0, 1);
    rd(`CFA_OFS_FIX_CTRL, 32'h0000_8015);
    // slow memory: entry arrives behind the pixel, coincident line edge not counted
    fixOn = 1'b0; memDelay <= 8'hC8; sync(1, 1); sync(0, 1); pix(30);
    repeat (250) @(posedge mclk);
    // the next pixels meet an entry already behind the window center
    pix(2);
    rd(`CFA_OFS_FIX_CTRL, 32'h0001_8015);
    wr(`CFA_OFS_FIX_CTRL, 32'h0001_0000);
    repeat (250) @(posedge mclk);
    rd(`CFA_OFS_FIX_CTRL, 32'h0);
    // every input window with companding on
    memDelay <= 8'h01; cmpEn = 1'b1; sync(1, 0);
    for (int w = 0; w < 8; w++) begin
      cmpWin = 3'(w);
      wr(`CFA_OFS_COMPANDING, {28'h0, 1'b1, cmpWin});
      rd(`CFA_OFS_COMPANDING, {28'h0, 1'b1, cmpWin});
      sync(0, 1); pix(8);
    end
    // falling polarity: the switch itself gives a coincident frame and line edge
    wr(`CFA_OFS_SYNC_POL, 32'h3);
    rd(`CFA_OFS_SYNC_POL, 32'h3);
    lineCnt = 0;
    sync(0, 1);
    repeat (20) @(posedge mclk);
    `CHK("pixel queue", 0, pixQ.size())
    `CHK("irq0 count", 2, nIrq0)
    `CHK("irq1 count", 4, nIrq1)
    results();
  end
endmodule

bind cfa_fault_fix cfa_fault_fix_chk cfa_fault_fix_chk_i (.mclk, .nrst, .regAddr,
  .regWdata, .regWr, .regRd, .regRdata, .pixValid, .memReq, .memAddr, .memAck,
  .memPixValid, .memPix, .frame_irq0, .frame_irq1);
